// *** src/fan_cfg_pkg.sv ***
/*
 * Constants shared by the fan range and ramp configuration block.
 * Assumes a 40 MHz device clock and a classic Wishbone register port.
 */
package fan_cfg_pkg;
    // ****************************************************************
    // Register map (word indices; byte address is index x4)
    // ****************************************************************
    localparam logic [7:0] IDX_SPAN1 = 8'h5F;
    localparam logic [7:0] IDX_SPAN2 = 8'h60;
    localparam logic [7:0] IDX_SPAN3 = 8'h61;
    localparam logic [7:0] IDX_SMOOTH1 = 8'h62;
    localparam logic [7:0] IDX_CTRL  = 8'h70;
    localparam logic [7:0] IDX_DUTY1 = 8'h71;
    localparam logic [7:0] IDX_DUTY2 = 8'h72;
    localparam logic [7:0] IDX_DUTY3 = 8'h73;
    localparam logic [7:0] IDX_STAT  = 8'h74;
    localparam int         ADDR_W    = 10;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] SPAN_RESET  = 8'hC4;
    localparam logic [7:0] SMOOTH_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] DUTY_RESET  = 8'hFF;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int RATE_LSB   = 0;
    localparam int HIGHF_BIT  = 3;
    localparam int SPAN_LSB   = 4;
    localparam int RAMP_LSB   = 0;
    localparam int RAMPEN_BIT = 3;
    localparam int SYNC_BIT   = 4;
    localparam int HOLD1_BIT  = 5;
    localparam int LOCK_BIT   = 0;
    localparam int SLOW_BIT   = 1;
    localparam int AUTO_BIT   = 2;
    localparam int BELOW_LSB  = 3;

    // ****************************************************************
    // Timing: slot per 1-count step, full scale 255 counts
    // ****************************************************************
    localparam int  CLK_HZ       = 40_000_000;
    localparam int  FULL_SCALE   = 255;
    localparam int  FAST_RAMP_MS = 37_500;
    localparam int  SLOW_RAMP_MS = 52_200;
    localparam int  FAST_SLOT_CYC = int'((64'(FAST_RAMP_MS) * CLK_HZ) / (1000 * FULL_SCALE));
    localparam int  SLOW_SLOT_CYC = int'((64'(SLOW_RAMP_MS) * CLK_HZ) / (1000 * FULL_SCALE));

    // Low-frequency drive rates in 0.1 Hz units
    localparam int  LF_RATE_DHZ [8] = '{110, 147, 221, 294, 353, 441, 588, 882};
    localparam int  HF_PERIOD_CYC   = 1785;
    localparam int  DUTY_STEPS      = 255;
endpackage : fan_cfg_pkg

// *** src/fan_drive_channel.sv ***
/*
 * One fan drive output: picks its duty (ramped or direct, floor hold) and
 * produces the pulse train at the low or high drive rate.
 * Assumes configuration and target duty come from the register file.
 */
`timescale 1ns/1ps
module fan_drive_channel
    import fan_cfg_pkg::*;
#(
    parameter int FAST_SLOT = FAST_SLOT_CYC,
    parameter int SLOW_SLOT = SLOW_SLOT_CYC
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [7:0] spanReg,
    input  wire logic [7:0] targetDuty,
    input  wire logic [7:0] minDuty,
    input  wire logic       autoMode,
    input  wire logic       belowFloor,
    input  wire logic       holdAtMin,
    input  wire logic       rampOn,
    input  wire logic [2:0] rampRate,
    input  wire logic       slowSlots,
    output logic            fanDrive,
    output logic [7:0]      dutyNow
);
    logic [7:0]  want;
    logic [7:0]  step;
    logic [21:0] slotCnt,  next_slotCnt;
    logic [7:0]  duty,     next_duty;
    logic [23:0] perCnt,   next_perCnt;
    logic        drive,    next_drive;
    logic [23:0] period;
    logic [31:0] onTime;

    // Floor hold below turn-on temperature
    always_comb begin
        if (autoMode && belowFloor)
            want = holdAtMin ? minDuty : 8'h00;
        else
            want = targetDuty;
        unique case (rampRate)
            3'h0: step = 8'h01;
            3'h1: step = 8'h02;
            3'h2: step = 8'h03;
            3'h3: step = 8'h04;
            3'h4: step = 8'h08;
            3'h5: step = 8'h0C;
            3'h6: step = 8'h18;
            3'h7: step = 8'h30;
        endcase
    end

    // Ramp engine: one increment per slot, clamped at the target
    always_comb begin
        next_slotCnt = slotCnt + 22'h000001;
        next_duty    = duty;
        if (!rampOn) begin
            next_duty    = want;
            next_slotCnt = 22'h000000;
        end else if (slotCnt >= 22'(slowSlots ? SLOW_SLOT - 1 : FAST_SLOT - 1)) begin
            next_slotCnt = 22'h000000;
            if (duty < want)
                next_duty = (want - duty > step) ? duty + step : want;
            else if (duty > want)
                next_duty = (duty - want > step) ? duty - step : want;
        end
    end

    // Period from the drive rate field, or the fixed high rate
    always_comb begin
        if (spanReg[HIGHF_BIT])
            period = 24'(HF_PERIOD_CYC);
        else
            period = 24'((CLK_HZ * 10) / LF_RATE_DHZ[spanReg[RATE_LSB +: 3]]);
        onTime = (32'(period) * 32'(duty)) / 32'(DUTY_STEPS);
        next_perCnt = (perCnt >= period - 24'h000001) ? 24'h000000 : perCnt + 24'h000001;
        next_drive  = (32'(perCnt) < onTime);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            slotCnt <= 22'h000000;
            duty    <= DUTY_RESET;
            perCnt  <= 24'h000000;
            drive   <= 1'b1;
        end else begin
            slotCnt <= next_slotCnt;
            duty    <= next_duty;
            perCnt  <= next_perCnt;
            drive   <= next_drive;
        end
    end

    assign fanDrive = drive;
    assign dutyNow  = duty;
endmodule : fan_drive_channel

// *** src/fan_pwm_range_and_ramp_config.sv ***
/*
 * Register file and drive outputs for three fans: span/rate registers,
 * ramp smoothing for the first remote channel, speed-sense sync select.
 * Assumes a classic Wishbone master on mclk; temperature decisions come in
 * as simple below-floor levels and per-channel minimum duties.
 */
// Local design decision: the Wishbone register port.
// What this block does
// - Rate field sets low-frequency drive rate
// - Bit 3 picks high or low drive
// - Bits 7:4 hold control temperature span
// - Three span/rate registers reset to C4
// - Lock blocks writes to these registers
// - Smoothing register at 62, resets zero
// - Enabled smoothing ramps duty, never steps
// - Ramp code selects increment 1 to 48
// - Normal slots: 10.8 s to 0.2 s (22-bit slot count)
// - Slow slots: 25.5 s to 0.5 s (22-bit slot count)
// - Bit 3 enables smoothing on remote one
// - Bit 4 syncs sense two to drive three
// - Bit 5 picks floor duty for drive one
// - Bits 6, 7 same for drives two, three
// - Default decodes to low drive 35.3 Hz
`timescale 1ns/1ps
module fan_pwm_range_and_ramp_config
    import fan_cfg_pkg::*;
#(
    parameter int FAST_SLOT = FAST_SLOT_CYC,
    parameter int SLOW_SLOT = SLOW_SLOT_CYC
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [2:0]        belowFloor,
    input  wire logic [7:0]        minDuty1,
    input  wire logic [7:0]        minDuty2,
    input  wire logic [7:0]        minDuty3,
    output logic                   fan_drive_one,
    output logic                   fan_drive_two,
    output logic                   fan_drive_three,
    output logic                   sense_two_sync_three
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]  span   [3];
    logic [7:0]  next_span [3];
    logic [7:0]  smooth, next_smooth;
    logic [7:0]  ctrl,  next_ctrl;
    logic [7:0]  duty   [3];
    logic [7:0]  next_duty [3];
    logic        ack,   next_ack;
    logic [31:0] rdat,  next_rdat;
    logic        syncSel, next_syncSel;
    logic [2:0]  drv;
    logic [2:0]  drvQ;
    logic [7:0]  dutyNow [3];
    logic [7:0]  minDuty [3];
    logic [7:0]  idx;
    logic        req;
    logic        wrEn;
    logic        locked;

    assign minDuty[0] = minDuty1;
    assign minDuty[1] = minDuty2;
    assign minDuty[2] = minDuty3;

    // ****************************************************************
    // Wishbone decode
    // ****************************************************************
    // Word index from the byte address; the low two address bits are ignored
    assign idx    = wb_adr_i[9:2];
    assign req    = wb_cyc_i && wb_stb_i && !ack;
    // Writes land at the edge where the master samples ack high
    assign wrEn   = wb_cyc_i && wb_stb_i && ack && wb_we_i && wb_sel_i[0];
    assign locked = ctrl[LOCK_BIT];

    // Register writes; lock makes span and smoothing read-only
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_span[i] = span[i];
            next_duty[i] = duty[i];
        end
        next_smooth = smooth;
        next_ctrl = ctrl;
        if (wrEn) begin
            unique case (idx)
                IDX_SPAN1: if (!locked) next_span[0] = wb_dat_i[7:0];
                IDX_SPAN2: if (!locked) next_span[1] = wb_dat_i[7:0];
                IDX_SPAN3: if (!locked) next_span[2] = wb_dat_i[7:0];
                IDX_SMOOTH1: if (!locked) next_smooth = wb_dat_i[7:0];
                // Lock is sticky until reset, as software cannot undo it
                IDX_CTRL:  next_ctrl = {wb_dat_i[7:1], wb_dat_i[0] | ctrl[0]};
                IDX_DUTY1: next_duty[0] = wb_dat_i[7:0];
                IDX_DUTY2: next_duty[1] = wb_dat_i[7:0];
                IDX_DUTY3: next_duty[2] = wb_dat_i[7:0];
                default:   next_ctrl = ctrl;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero but still acknowledge
    always_comb begin
        next_ack  = req;
        next_rdat = 32'h00000000;
        if (req && !wb_we_i) begin
            unique case (idx)
                IDX_SPAN1: next_rdat = {24'h000000, span[0]};
                IDX_SPAN2: next_rdat = {24'h000000, span[1]};
                IDX_SPAN3: next_rdat = {24'h000000, span[2]};
                IDX_SMOOTH1: next_rdat = {24'h000000, smooth};
                IDX_CTRL:  next_rdat = {24'h000000, ctrl};
                IDX_DUTY1: next_rdat = {24'h000000, duty[0]};
                IDX_DUTY2: next_rdat = {24'h000000, duty[1]};
                IDX_DUTY3: next_rdat = {24'h000000, duty[2]};
                IDX_STAT:  next_rdat = {16'h0000, 5'h00, drvQ, dutyNow[0]};
                default:   next_rdat = 32'h00000000;
            endcase
        end
        next_syncSel = smooth[SYNC_BIT];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                span[i] <= SPAN_RESET;
                duty[i] <= DUTY_RESET;
            end
            smooth  <= SMOOTH_RESET;
            ctrl    <= CTRL_RESET;
            ack     <= 1'b0;
            rdat    <= 32'h00000000;
            syncSel <= 1'b0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                span[i] <= next_span[i];
                duty[i] <= next_duty[i];
            end
            smooth  <= next_smooth;
            ctrl    <= next_ctrl;
            ack     <= next_ack;
            rdat    <= next_rdat;
            syncSel <= next_syncSel;
        end
    end

    // ****************************************************************
    // Drive channels
    // ****************************************************************
    // Only the first remote channel has ramp smoothing here
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_ch
            fan_drive_channel #(
                .FAST_SLOT (FAST_SLOT),
                .SLOW_SLOT (SLOW_SLOT)
            ) u_ch (
                .mclk       (mclk),
                .reset_n    (reset_n),
                .spanReg    (span[g]),
                .targetDuty (duty[g]),
                .minDuty    (minDuty[g]),
                .autoMode   (ctrl[AUTO_BIT]),
                .belowFloor (belowFloor[g]),
                .holdAtMin  (smooth[HOLD1_BIT + g]),
                .rampOn     ((g == 0) && smooth[RAMPEN_BIT]),
                .rampRate   (smooth[RAMP_LSB +: 3]),
                .slowSlots  (ctrl[SLOW_BIT]),
                .fanDrive   (drv[g]),
                .dutyNow    (dutyNow[g])
            );
        end
    endgenerate

    // Outputs registered once more so each comes straight from a flop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            drvQ <= 3'b111;
        else
            drvQ <= drv;
    end

    assign fan_drive_one        = drvQ[0];
    assign fan_drive_two        = drvQ[1];
    assign fan_drive_three      = drvQ[2];
    assign sense_two_sync_three = syncSel;
    assign wb_ack_o             = ack;
    assign wb_dat_o             = rdat;
endmodule : fan_pwm_range_and_ramp_config

// *** sim/fan_cfg_checker.sv ***
/* Checker for the fan range/ramp block: bus handshake, lockable registers,
   sync pin and floor holds. Assumes it is bound to the top module. */
`timescale 1ns/1ps
module fan_cfg_checker
    import fan_cfg_pkg::*;
(
    input wire logic              mclk,
    input wire logic              reset_n,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [2:0]        belowFloor,
    input wire logic [7:0]        minDuty1,
    input wire logic [7:0]        minDuty2,
    input wire logic [7:0]        minDuty3,
    input wire logic              fan_drive_one,
    input wire logic              fan_drive_two,
    input wire logic              fan_drive_three,
    input wire logic              sense_two_sync_three
);
    // ****
    // Shadow state
    // ****
    logic [7:0]  mirror [4];
    logic [7:0]  next_mirror [4];
    logic        locked, next_locked, autoM, next_autoM;
    logic [11:0] cnt2, cnt3, next_cnt2, next_cnt3;
    wire  [7:0]  idx   = wb_adr_i[9:2];
    wire         wrHit = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    wire         inCfg = (idx >= IDX_SPAN1) && (idx <= IDX_SMOOTH1);
    wire  [1:0]  slot  = 2'(idx - IDX_SPAN1);
    wire         off2  = autoM & belowFloor[1] & ~mirror[3][6] & mirror[1][3];
    wire         full3 = autoM & belowFloor[2] & mirror[3][7] & mirror[2][3] & (&minDuty3);

    // Mirror takes writes at the ack edge, as the design does
    always_comb begin
        next_mirror = mirror;
        next_locked = locked | (wrHit & (idx == IDX_CTRL) & wb_dat_i[LOCK_BIT]);
        next_autoM = (wrHit && idx == IDX_CTRL) ? wb_dat_i[AUTO_BIT] : autoM;
        if (wrHit && inCfg && !locked) begin
            next_mirror[slot] = wb_dat_i[7:0];
        end
        next_cnt2 = !off2 ? 12'h000 : (cnt2 == 12'hFA0) ? cnt2 : cnt2 + 12'h001;
        next_cnt3 = !full3 ? 12'h000 : (cnt3 == 12'hFA0) ? cnt3 : cnt3 + 12'h001;
    end
    // Counters saturate so a long hold cannot wrap
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mirror <= '{SPAN_RESET, SPAN_RESET, SPAN_RESET, SMOOTH_RESET};
            {locked, autoM, cnt2, cnt3} <= '0;
        end else begin
            mirror <= next_mirror;
            {locked, autoM, cnt2, cnt3} <= {next_locked, next_autoM, next_cnt2, next_cnt3};
        end
    end
    // ****
    // Properties
    // ****
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    req_gets_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    cfg_readback_a: assert property (
        wb_ack_o && !wb_we_i && inCfg |-> wb_dat_o == {24'h0, mirror[slot]})
        else $error("register read differs from shadow");
    upper_zero_a: assert property (
        wb_ack_o && !wb_we_i && idx != IDX_STAT |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    sync_pin_a: assert property (
        $stable(mirror[3][4]) [*3] |-> sense_two_sync_three == mirror[3][4])
        else $error("sync pin differs from bit 4");
    floor_off_a: assert property (cnt2 == 12'hFA0 |-> !fan_drive_two)
        else $error("drive two not off below floor");
    floor_min_a: assert property (cnt3 == 12'hFA0 |-> fan_drive_three)
        else $error("drive three not at minimum below floor");
endmodule : fan_cfg_checker

bind fan_pwm_range_and_ramp_config fan_cfg_checker watch (.mclk, .reset_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .belowFloor,
    .minDuty1, .minDuty2, .minDuty3, .fan_drive_one, .fan_drive_two, .fan_drive_three,
    .sense_two_sync_three);

// *** sim/fan_load_model.sv ***
/* Fan on one drive output: measures cycles between rising edges.
   Assumes the drive is a registered output on mclk. */
`timescale 1ns/1ps
module fan_load_model (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        fanDrive,
    output logic      [15:0] period
);
    logic        lastDrive;
    logic [15:0] run;

    // A stalled drive leaves the last period standing, as a real fan would
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {lastDrive, run, period} <= {1'b1, 32'h0};
        end else begin
            lastDrive <= fanDrive;
            run <= (fanDrive && !lastDrive) ? 16'h0001 : run + 16'h0001;
            if (fanDrive && !lastDrive) period <= run;
        end
    end
endmodule : fan_load_model

// *** sim/tb.sv ***
/* Bench: bus reads checked against notes queued by the driver.
   Assumes the checker is bound and slots are shortened to 4 and 8 cycles. */
`timescale 1ns/1ps
module tb
    import fan_cfg_pkg::*;
;
    typedef struct { logic [31:0] exp; logic [31:0] msk; } note_s;
    logic        mclk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'hF;
    logic [2:0]  belowFloor = 3'h0;
    logic [7:0]  minDuty1 = 8'h00, minDuty2 = 8'h00, minDuty3 = 8'h00;
    logic [31:0] dat = 32'h0, datOut, rnd = 32'h5EF92307;
    logic        ack, drv1, drv2, drv3, syncPin;
    logic [15:0] period2;
    logic [7:0]  shadow [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    int          err_total = 0, checks_done = 0, cycles = 0;
    int          inc [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    note_s       notes [$];

    always #12.5 mclk = ~mclk;
    fan_pwm_range_and_ramp_config #(.FAST_SLOT(4), .SLOW_SLOT(8)) uut (.mclk(mclk),
        .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datOut), .wb_ack_o(ack),
        .belowFloor(belowFloor), .minDuty1(minDuty1), .minDuty2(minDuty2),
        .minDuty3(minDuty3), .fan_drive_one(drv1), .fan_drive_two(drv2),
        .fan_drive_three(drv3), .sense_two_sync_three(syncPin));
    fan_load_model fan2 (.mclk(mclk), .reset_n(reset_n), .fanDrive(drv2), .period(period2));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        // A read whose note was never judged counts as a mismatch
        if (notes.size() != 0) err_total++;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // Request held until ack is sampled high, then released
    task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge mclk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {i, 2'b00};
        dat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e & m, m});
        wb(1'b0, i, 32'h0);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle
    task automatic do_reset();
        reset_n <= 1'b0;
        idle(20);
        reset_n <= 1'b1;
    endtask : do_reset

    // Oldest note judges each read as its ack arrives
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
            check(datOut & notes[0].msk, notes[0].exp);
            void'(notes.pop_front());
        end
    end
    // Hang guard, well above the expected run of some 20300 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        do_reset();
        for (int k = 0; k < 3; k++) rd(8'(IDX_SPAN1 + k), SPAN_RESET, '1);
        rd(IDX_SMOOTH1, SMOOTH_RESET, '1);
        rd(8'h10, 32'h0, '1);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            shadow[k] = {rnd[7:4], 1'b1, rnd[2:0]};
            wb(1'b1, 8'(IDX_SPAN1 + k), {24'h0, shadow[k]});
            rd(8'(IDX_SPAN1 + k), {24'h0, shadow[k]}, '1);
        end
        sel <= 4'h0;
        wb(1'b1, IDX_SPAN3, 32'h0);
        sel <= 4'hF;
        rd(IDX_SPAN3, {24'h0, shadow[2]}, '1);
        $display("registers done");
        wb(1'b1, IDX_CTRL, 32'h04);
        wb(1'b1, IDX_DUTY1, 32'h00);
        rd(IDX_STAT, 32'h00, 32'hFF);
        for (int c = 0; c < 8; c++) begin
            // Target F5 is no multiple of most steps, so the clamp is exercised
            wb(1'b1, IDX_SMOOTH1, 32'(8 + c));
            wb(1'b1, IDX_DUTY1, 32'hF5);
            rd(IDX_STAT, 32'h00, 32'h80);
            idle((256 / inc[c] + 3) * 4);
            rd(IDX_STAT, 32'hF5, 32'hFF);
            wb(1'b1, IDX_DUTY1, 32'h00);
            rd(IDX_STAT, 32'h80, 32'h80);
            idle((256 / inc[c] + 3) * 4);
            rd(IDX_STAT, 32'h00, 32'hFF);
        end
        wb(1'b1, IDX_CTRL, 32'h06);
        wb(1'b1, IDX_SMOOTH1, 32'h08);
        wb(1'b1, IDX_DUTY1, 32'hF0);
        idle(900);
        rd(IDX_STAT, 32'h00, 32'h80);
        idle(1100);
        rd(IDX_STAT, 32'hF0, 32'hFF);
        $display("ramp done");
        rnd = lfsr(rnd);
        minDuty1 <= rnd[7:0];
        {minDuty2, minDuty3} <= 16'hFFFF;
        wb(1'b1, IDX_CTRL, 32'h04);
        wb(1'b1, IDX_SMOOTH1, 32'h00);
        belowFloor <= 3'h7;
        idle(4500);
        rd(IDX_STAT, 32'h0, 32'h7FF);
        wb(1'b1, IDX_SMOOTH1, 32'hE0);
        idle(4500);
        rd(IDX_STAT, {21'h0, 3'b110, rnd[7:0]}, 32'h6FF);
        belowFloor <= 3'h0;
        wb(1'b1, IDX_DUTY2, 32'h80);
        idle(4000);
        check(32'(period2), 32'(HF_PERIOD_CYC));
        $display("floor and drive done");
        wb(1'b1, IDX_SMOOTH1, 32'h10);
        idle(3);
        check({31'h0, syncPin}, 32'h1);
        wb(1'b1, IDX_CTRL, 32'h05);
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, 8'(IDX_SPAN1 + k), {24'h0, ~shadow[k]});
            rd(8'(IDX_SPAN1 + k), {24'h0, shadow[k] | (k == 3 ? 8'h10 : 8'h00)}, '1);
        end
        do_reset();
        rd(IDX_SPAN2, SPAN_RESET, '1);
        check({31'h0, syncPin}, 32'h0);
        wb(1'b1, IDX_SPAN2, 32'h5A);
        rd(IDX_SPAN2, 32'h5A, '1);
        $display("lock and reset done");
        idle(2);
        close_out();
    end
endmodule : tb
